// ---- rtl/mts_consts.vh ----
/*
 Constants for the multiturn link block: register offsets, field positions,
 reset values, mode codes and link timing.
 Assumes nothing; holds definitions only.
*/
`ifndef MTS_CONSTS_VH
`define MTS_CONSTS_VH

// Register offsets on the configuration port.
`define MTS_ADDR_DIR_ERR 8'h0E
`define MTS_ADDR_OFFSET 8'h0F
`define MTS_ADDR_MODE_SYNC 8'h10

// Field positions.
`define MTS_DIR_BIT 5
`define MTS_ERR_HI 7
`define MTS_ERR_LO 6
`define MTS_OFS_HI 7
`define MTS_OFS_LO 4
`define MTS_MODE_HI 3
`define MTS_MODE_LO 0
`define MTS_SBL_HI 5
`define MTS_SBL_LO 4
`define MTS_CHK_BIT 6
`define MTS_PASS_BIT 7

// Reset values.
`define MTS_RST_REG 8'h00

// Error bit evaluation codes.
`define MTS_ERR_NONE 2'h0
`define MTS_ERR_LOW 2'h1
`define MTS_ERR_HIGH 2'h3

// Port A modes allowing the daisy chain.
`define MTS_PA_BISS 3'h2
`define MTS_PA_SSI_LO 3'h5
`define MTS_PA_SSI_HI 3'h7

// Link timing: half period of the turn clock in ns, clock period in ns.
`define MTS_HALF_NS 1000
`define MTS_CLK_NS 100
`define MTS_HALF_CYC (`MTS_HALF_NS / `MTS_CLK_NS)
// Pause after a word before the next read, in ns.
`define MTS_PAUSE_NS 30000
`define MTS_PAUSE_CYC (`MTS_PAUSE_NS / `MTS_CLK_NS)
// Period of automatic checks, in cycles.
`define MTS_CHECK_CYC 100000

`endif

// ---- rtl/mts_sync2.v ----
/*
 Two flip-flop synchroniser for one level from outside the clock domain.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module mts_sync2 (
    clock,
    sys_rst,
    async_in,
    sync_out
);
    input wire clock;
    input wire sys_rst;
    input wire async_in;
    output reg sync_out;

    reg meta_r;

    // The first stage is read only by the second stage.
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ---- rtl/mts_word_align.v ----
/*
 Splits a received turn word, applies inversion and offset, and checks
 its sync bits against the low bits of the internal counter.
 Assumes the word is right aligned with the last received bit in bit 0.
*/
`timescale 1ns/1ns
module mts_word_align (
    word_in,
    data_bits,
    sync_bits,
    err_bits,
    invert,
    offset,
    internal_cnt,
    turn_out,
    sync_ok
);
    input wire [31:0] word_in;
    input wire [4:0] data_bits;
    input wire [2:0] sync_bits;
    input wire [0:0] err_bits;
    input wire invert;
    input wire [3:0] offset;
    input wire [23:0] internal_cnt;
    output reg [23:0] turn_out;
    output reg sync_ok;

    reg [31:0] body;
    reg [31:0] mask;
    reg [31:0] raw;
    reg [3:0] smask;
    reg [3:0] sync_field;
    reg [3:0] ref_bits;
    reg [3:0] diff;
    reg [4:0] total;

    // Strip the error bit, split data from sync bits, then correct.
    always @* begin
        total = data_bits + {2'b00, sync_bits};
        body = word_in >> err_bits;
        smask = (4'h1 << sync_bits) - 4'h1;
        sync_field = body[3:0] & smask;
        mask = (32'h1 << data_bits) - 32'h1;
        raw = (body >> sync_bits) & mask;
        if (invert) begin
            raw = (~raw) & mask;
            sync_field = (~sync_field) & smask;
        end
        raw = (raw + {28'h0, offset}) & mask;
        // The sync bits carry the fraction of a turn; a wrap of the fraction
        // against the counted cycle moves the turn count by one.
        ref_bits = internal_cnt[3:0] & smask;
        diff = (sync_field - ref_bits) & smask;
        sync_ok = (diff == 4'h0) || (diff == 4'h1) || (diff == smask);
        turn_out = raw[23:0];
        if (total == 5'h0) begin
            sync_ok = 1'b0;
        end
    end
endmodule

// ---- rtl/mts_top.v ----
/*
 Multiturn link controller: reads the turn sensor as clock master,
 keeps a 24-bit turn counter, verifies it, and can chain the host
 clock through to the sensor and the sensor data back to the host.
 Assumes a byte write/read configuration port and singleturn cycle
 events from logic on the same clock.
*/
`timescale 1ns/1ns
`include "mts_consts.vh"

// Overview of operation
// - At startup load the turn counter from the first good external word.
// - After startup count turns up or down on each singleturn cycle.
// - A failed startup read is retried until one succeeds.
// - Mode zero: the 24-bit turn counter extends the singleturn position.
// - Modes 0xB to 0xF read 4, 8, 12, 16, 18 turn bits.
// - Modes 1-6 give 1-6 singleturn bits; 7-A give 3-6 plus 12 turn bits.
// - External singleturn bits feed incremental, commutation and scaled outputs.
// - Sync length codes 0 to 3 select 1 to 4 sync bits.
// - Counter aligns to the external word at startup only, while phase stays in tolerance.
// - Direction invert reverses the external turn code direction.
// - Error evaluation: none, low active, reserved, high active error bit.
// - Word length is data bits plus sync bits plus optional error bit.
// - The four-bit offset is added to read data before alignment.
// - Periodic check bit or verify command compares counter with a fresh read.
// - A mismatch on verification sets the turn mismatch flag.
// - Pass-through allowed in BiSS mode, or SSI modes with the option bit.
// - Chain mode routes host clock to turn clock and turn data inward.
// - In chain mode the sensor is slave ID 0, local device ID 1.
// - Pending port mode applies only at soft reset; a system reset sets port mode zero.
module mts_top #(
    parameter CHECK_CYC = `MTS_CHECK_CYC
) (
    clock,
    sys_rst,
    cfg_wr,
    cfg_rd,
    cfg_addr,
    cfg_wdata,
    cfg_rdata,
    st_cycle_up,
    st_cycle_down,
    turn_verify_cmd,
    mismatch_clear,
    soft_reset,
    ssi_option_bit,
    port_a_mode_pending,
    access_level_pending,
    port_a_mode,
    access_level,
    host_clock_in,
    serial_host_data_in,
    turn_data_in,
    turn_clock_out,
    host_data_sel,
    chain_active,
    turn_count,
    ext_st_bits,
    ext_st_width,
    startup_done,
    turn_mismatch_flag,
    err_flag
);
    input wire clock;
    input wire sys_rst;
    input wire cfg_wr;
    input wire cfg_rd;
    input wire [7:0] cfg_addr;
    input wire [7:0] cfg_wdata;
    output reg [7:0] cfg_rdata;
    input wire st_cycle_up;
    input wire st_cycle_down;
    input wire turn_verify_cmd;
    input wire mismatch_clear;
    input wire soft_reset;
    input wire ssi_option_bit;
    input wire [2:0] port_a_mode_pending;
    input wire [1:0] access_level_pending;
    output reg [2:0] port_a_mode;
    output reg [1:0] access_level;
    input wire host_clock_in;
    input wire serial_host_data_in;
    input wire turn_data_in;
    output wire turn_clock_out;
    output wire host_data_sel;
    output wire chain_active;
    output reg [23:0] turn_count;
    output reg [5:0] ext_st_bits;
    output reg [2:0] ext_st_width;
    output reg startup_done;
    output reg turn_mismatch_flag;
    output reg err_flag;

    localparam ST_IDLE = 3'd0;
    localparam ST_CLK_LO = 3'd1;
    localparam ST_CLK_HI = 3'd2;
    localparam ST_EVAL = 3'd3;
    localparam ST_PAUSE = 3'd4;

    reg [7:0] dir_err_r;
    reg [7:0] offset_r;
    reg [7:0] mode_sync_r;
    reg [2:0] state_r;
    reg [15:0] tmr_r;
    reg [4:0] bit_cnt_r;
    reg [31:0] shift_r;
    reg clk_out_r;
    reg verify_r;
    reg verify_pend_r;
    reg [16:0] chk_cnt_r;
    wire host_clk_s;
    wire turn_data_s;
    wire [23:0] aligned_turn;
    wire sync_ok;

    reg [4:0] data_bits;
    reg [2:0] st_width;
    reg [4:0] word_len;
    reg err_seen;

    wire [3:0] src_mode = mode_sync_r[`MTS_MODE_HI:`MTS_MODE_LO];
    wire [2:0] sync_bits = {1'b0, mode_sync_r[`MTS_SBL_HI:`MTS_SBL_LO]} + 3'h1;
    wire [1:0] err_eval = dir_err_r[`MTS_ERR_HI:`MTS_ERR_LO];
    wire err_en = (err_eval == `MTS_ERR_LOW) || (err_eval == `MTS_ERR_HIGH);
    wire ext_used = (src_mode != 4'h0);

    // Bits in the data part of the word for a source mode.
    function [4:0] mode_bits;
        input [3:0] m;
        begin
            case (m)
                4'h0: mode_bits = 5'd0;
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: mode_bits = {1'b0, m};
                4'h7, 4'h8, 4'h9, 4'hA: mode_bits = {1'b0, m} + 5'd8;
                4'hB: mode_bits = 5'd4;
                4'hC: mode_bits = 5'd8;
                4'hD: mode_bits = 5'd12;
                4'hE: mode_bits = 5'd16;
                default: mode_bits = 5'd18;
            endcase
        end
    endfunction

    // Derived widths of the external word.
    always @* begin
        data_bits = mode_bits(src_mode);
        if (src_mode >= 4'h1 && src_mode <= 4'h6) begin
            st_width = src_mode[2:0];
        end else if (src_mode >= 4'h7 && src_mode <= 4'hA) begin
            st_width = src_mode[2:0] - 3'h4;
        end else begin
            st_width = 3'h0;
        end
        word_len = data_bits + {2'b00, sync_bits} + {4'h0, err_en};
        if (err_eval == `MTS_ERR_LOW) begin
            err_seen = ~shift_r[0];
        end else if (err_eval == `MTS_ERR_HIGH) begin
            err_seen = shift_r[0];
        end else begin
            err_seen = 1'b0;
        end
    end

    // Pass-through only in BiSS mode or SSI modes with the option bit.
    assign chain_active = mode_sync_r[`MTS_PASS_BIT] &&
        ((port_a_mode == `MTS_PA_BISS) ||
         (ssi_option_bit && port_a_mode >= `MTS_PA_SSI_LO &&
          port_a_mode <= `MTS_PA_SSI_HI));
    // In the chain the sensor answers as ID 0, this device as ID 1.
    assign turn_clock_out = chain_active ? host_clock_in : clk_out_r;
    assign host_data_sel = chain_active ? turn_data_in : serial_host_data_in;

    mts_sync2 u_sync_clk (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(host_clock_in),
        .sync_out(host_clk_s)
    );

    mts_sync2 u_sync_dat (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(turn_data_in),
        .sync_out(turn_data_s)
    );

    mts_word_align u_align (
        .word_in(shift_r),
        .data_bits(data_bits),
        .sync_bits(sync_bits),
        .err_bits(err_en),
        .invert(dir_err_r[`MTS_DIR_BIT]),
        .offset(offset_r[`MTS_OFS_HI:`MTS_OFS_LO]),
        .internal_cnt(turn_count),
        .turn_out(aligned_turn),
        .sync_ok(sync_ok)
    );

    // Configuration register writes and reads.
    always @(posedge clock) begin
        if (sys_rst) begin
            dir_err_r <= `MTS_RST_REG;
            offset_r <= `MTS_RST_REG;
            mode_sync_r <= `MTS_RST_REG;
            cfg_rdata <= 8'h00;
        end else begin
            if (cfg_wr) begin
                case (cfg_addr)
                    `MTS_ADDR_DIR_ERR: dir_err_r <= cfg_wdata;
                    `MTS_ADDR_OFFSET: offset_r <= cfg_wdata;
                    `MTS_ADDR_MODE_SYNC: mode_sync_r <= cfg_wdata;
                    default: ;
                endcase
            end
            if (cfg_rd) begin
                case (cfg_addr)
                    `MTS_ADDR_DIR_ERR: cfg_rdata <= dir_err_r;
                    `MTS_ADDR_OFFSET: cfg_rdata <= offset_r;
                    `MTS_ADDR_MODE_SYNC: cfg_rdata <= mode_sync_r;
                    default: cfg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Pending interface settings take effect only at soft reset; reset loads zero.
    always @(posedge clock) begin
        if (sys_rst) begin
            port_a_mode <= 3'h0;
            access_level <= 2'h0;
        end else if (soft_reset) begin
            port_a_mode <= port_a_mode_pending;
            access_level <= access_level_pending;
        end
    end

    // Periodic check timer; a request is held until a read starts.
    always @(posedge clock) begin
        if (sys_rst) begin
            chk_cnt_r <= 17'h0;
            verify_pend_r <= 1'b0;
        end else begin
            if (mode_sync_r[`MTS_CHK_BIT] && startup_done &&
                chk_cnt_r == CHECK_CYC[16:0] - 17'h1) begin
                chk_cnt_r <= 17'h0;
            end else if (mode_sync_r[`MTS_CHK_BIT] && startup_done) begin
                chk_cnt_r <= chk_cnt_r + 17'h1;
            end
            if ((turn_verify_cmd || (mode_sync_r[`MTS_CHK_BIT] && startup_done &&
                chk_cnt_r == CHECK_CYC[16:0] - 17'h1)) && ext_used) begin
                verify_pend_r <= 1'b1;
            end else if (state_r == ST_IDLE && startup_done && !chain_active) begin
                verify_pend_r <= 1'b0;
            end
        end
    end

    // Read sequencer on the turn link, turn counter and flags.
    always @(posedge clock) begin
        if (sys_rst || soft_reset) begin
            state_r <= ST_IDLE;
            tmr_r <= 16'h0;
            bit_cnt_r <= 5'h0;
            shift_r <= 32'h0;
            clk_out_r <= 1'b1;
            verify_r <= 1'b0;
            turn_count <= 24'h0;
            ext_st_bits <= 6'h0;
            ext_st_width <= 3'h0;
            startup_done <= 1'b0;
            turn_mismatch_flag <= 1'b0;
            err_flag <= 1'b0;
        end else begin
            ext_st_width <= st_width;
            if (startup_done && st_cycle_up && !st_cycle_down) begin
                turn_count <= turn_count + 24'h1;
            end else if (startup_done && st_cycle_down && !st_cycle_up) begin
                turn_count <= turn_count - 24'h1;
            end
            if (mismatch_clear) begin
                turn_mismatch_flag <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    clk_out_r <= 1'b1;
                    tmr_r <= 16'h0;
                    bit_cnt_r <= 5'h0;
                    if (!ext_used) begin
                        startup_done <= 1'b1;
                    end else if (!chain_active && (!startup_done || verify_pend_r)) begin
                        verify_r <= startup_done;
                        state_r <= ST_CLK_LO;
                    end
                end
                ST_CLK_LO: begin
                    clk_out_r <= 1'b0;
                    if (tmr_r == `MTS_HALF_CYC - 1) begin
                        tmr_r <= 16'h0;
                        state_r <= ST_CLK_HI;
                    end else begin
                        tmr_r <= tmr_r + 16'h1;
                    end
                end
                ST_CLK_HI: begin
                    clk_out_r <= 1'b1;
                    if (tmr_r == `MTS_HALF_CYC - 1) begin
                        tmr_r <= 16'h0;
                        shift_r <= {shift_r[30:0], turn_data_s};
                        if (bit_cnt_r == word_len) begin
                            state_r <= ST_EVAL;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 5'h1;
                            state_r <= ST_CLK_LO;
                        end
                    end else begin
                        tmr_r <= tmr_r + 16'h1;
                    end
                end
                ST_EVAL: begin
                    // The first clock pulse only latches the sensor; word_len
                    // further bits follow, so bit 0 is the last bit received.
                    err_flag <= err_seen;
                    if (err_seen || !sync_ok) begin
                        if (verify_r) begin
                            turn_mismatch_flag <= 1'b1;
                        end
                        state_r <= ST_PAUSE;
                    end else if (!startup_done) begin
                        turn_count <= aligned_turn;
                        ext_st_bits <= shift_r[5:0];
                        startup_done <= 1'b1;
                        state_r <= ST_PAUSE;
                    end else begin
                        if (aligned_turn != (turn_count & ((24'h1 << data_bits) - 24'h1))) begin
                            turn_mismatch_flag <= 1'b1;
                        end
                        ext_st_bits <= shift_r[5:0];
                        state_r <= ST_PAUSE;
                    end
                end
                ST_PAUSE: begin
                    if (tmr_r == `MTS_PAUSE_CYC - 1) begin
                        tmr_r <= 16'h0;
                        state_r <= ST_IDLE;
                    end else begin
                        tmr_r <= tmr_r + 16'h1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // The host clock sync output is not used yet.
    wire unused_ok = host_clk_s & 1'b0;
endmodule

// ---- test/mts_sensor_model.sv ----
/*
 Model of the external SSI turn sensor.
 Assumes the controller is clock master, turn clock idle high.
*/
`timescale 1ns/1ns
module mts_sensor_model (
    input wire clock,
    input wire turn_clock_out,
    input wire [31:0] word,
    input wire [4:0] word_len,
    output logic turn_data_in = 1'b1,
    output logic [7:0] frames = 8'h00,
    output logic [5:0] last_len = 6'h00
);
    logic clk_d = 1'b1;
    logic [31:0] sh = 32'h0;
    logic [5:0] nfall = 6'h00;
    logic [5:0] quiet = 6'h00;

    // Latch the word on the first falling edge, then shift one bit per period.
    always @(posedge clock) begin
        clk_d <= turn_clock_out;
        if (clk_d && !turn_clock_out) begin
            quiet <= 6'h00;
            nfall <= nfall + 6'h01;
            if (nfall == 6'h00) begin
                sh <= word << (32 - word_len);
            end else begin
                turn_data_in <= sh[31];
                sh <= sh << 1;
            end
        end else if (quiet == 6'd30) begin
            if (nfall != 6'h00) begin
                frames <= frames + 8'h01;
                last_len <= nfall;
            end
            nfall <= 6'h00;
            turn_data_in <= 1'b1; // Released line returns to its pull-up.
        end else begin
            quiet <= quiet + 6'h01;
        end
    end
endmodule

// ---- test/mts_top_monitor.sv ----
/*
 Port checks for the multiturn link controller.
 Assumes it is bound into mts_top.
*/
`timescale 1ns/1ns
`include "mts_consts.vh"
module mts_top_monitor (
    input wire clock,
    input wire sys_rst,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [7:0] cfg_rdata,
    input wire st_cycle_up,
    input wire st_cycle_down,
    input wire mismatch_clear,
    input wire soft_reset,
    input wire ssi_option_bit,
    input wire [2:0] port_a_mode_pending,
    input wire [2:0] port_a_mode,
    input wire host_clock_in,
    input wire serial_host_data_in,
    input wire turn_data_in,
    input wire turn_clock_out,
    input wire host_data_sel,
    input wire chain_active,
    input wire [23:0] turn_count,
    input wire startup_done,
    input wire turn_mismatch_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Unmapped offsets read back as zero.
    property p_unmapped_zero;
        cfg_rd && cfg_addr != `MTS_ADDR_DIR_ERR && cfg_addr != `MTS_ADDR_OFFSET
            && cfg_addr != `MTS_ADDR_MODE_SYNC |=> cfg_rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // Chain mode passes clock and data straight through.
    property p_chain_clock;
        chain_active |-> turn_clock_out == host_clock_in;
    endproperty
    a_chain_clock: assert property (p_chain_clock) else $error("clock not passed");
    property p_chain_data;
        chain_active |-> host_data_sel == turn_data_in;
    endproperty
    a_chain_data: assert property (p_chain_data) else $error("sensor data not selected");
    property p_host_data;
        !chain_active |-> host_data_sel == serial_host_data_in;
    endproperty
    a_host_data: assert property (p_host_data) else $error("host data not selected");

    // Chain mode only in the permitted port modes.
    property p_chain_allowed;
        chain_active |-> port_a_mode == 3'h2 || (port_a_mode >= 3'h5 && ssi_option_bit);
    endproperty
    a_chain_allowed: assert property (p_chain_allowed) else $error("chain in bad mode");

    // Counting on singleturn cycles after startup.
    property p_count_up;
        startup_done && st_cycle_up && !st_cycle_down && !soft_reset
            |=> turn_count == $past(turn_count) + 24'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count up wrong");
    property p_count_down;
        startup_done && st_cycle_down && !st_cycle_up && !soft_reset
            |=> turn_count == $past(turn_count) - 24'h1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("count down wrong");

    // Mismatch flag is sticky until cleared.
    property p_flag_sticky;
        turn_mismatch_flag && !mismatch_clear && !soft_reset |=> turn_mismatch_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("mismatch flag lost");

    // Pending port mode is adopted only on soft reset.
    property p_mode_adopt;
        soft_reset |=> port_a_mode == $past(port_a_mode_pending);
    endproperty
    a_mode_adopt: assert property (p_mode_adopt) else $error("pending mode not adopted");
    property p_mode_hold;
        !soft_reset |=> $stable(port_a_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("port mode changed");
endmodule

bind mts_top mts_top_monitor u_mts_top_monitor (.*);

// ---- test/tb_mts_top.sv ----
/*
 Self-checking bench for the multiturn link controller.
 Assumes the checker binds itself in.
*/
`timescale 1ns/1ns
`include "mts_consts.vh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb_mts_top;
    logic clock = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, ssi_option_bit = 1'b0;
    logic host_clock_in = 1'b1, serial_host_data_in = 1'b0, ok;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, r;
    logic [4:0] pl = 5'h00, m_len = 5'd10;
    logic [2:0] port_a_mode_pending = 3'h0;
    logic [1:0] access_level_pending = 2'h0;
    logic [31:0] m_word = 32'h0;
    logic [23:0] d, ce, cs;
    logic [23:0] exp_q[$], seen_q[$];
    string name_q[$], cn;
    int i, k, n0, cyc = 0, bad_count = 0, checks = 0;
    wire [7:0] cfg_rdata, frames;
    wire [2:0] port_a_mode, ext_st_width;
    wire [1:0] access_level;
    wire [23:0] turn_count;
    wire [5:0] ext_st_bits, m_last;
    wire turn_data_in, turn_clock_out, host_data_sel, chain_active, startup_done;
    wire turn_mismatch_flag, err_flag;

    mts_top #(.CHECK_CYC(200)) u_mts_top (.clock(clock), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .st_cycle_up(pl[0]), .st_cycle_down(pl[1]), .turn_verify_cmd(pl[2]),
        .mismatch_clear(pl[3]), .soft_reset(pl[4]), .ssi_option_bit(ssi_option_bit),
        .port_a_mode_pending(port_a_mode_pending), .access_level_pending(access_level_pending),
        .port_a_mode(port_a_mode), .access_level(access_level), .host_clock_in(host_clock_in),
        .serial_host_data_in(serial_host_data_in), .turn_data_in(turn_data_in),
        .turn_clock_out(turn_clock_out), .host_data_sel(host_data_sel),
        .chain_active(chain_active), .turn_count(turn_count), .ext_st_bits(ext_st_bits),
        .ext_st_width(ext_st_width), .startup_done(startup_done),
        .turn_mismatch_flag(turn_mismatch_flag), .err_flag(err_flag));
    mts_sensor_model u_mts_sensor_model (.clock(clock), .turn_clock_out(turn_clock_out),
        .word(m_word), .word_len(m_len), .turn_data_in(turn_data_in), .frames(frames),
        .last_len(m_last));

    // Clock of 100 ns period.
    always #50 clock = ~clock;

    // Compare every queued note, oldest first.
    always @(negedge clock) while (exp_q.size() != 0) begin
        cn = name_q.pop_front();
        ce = exp_q.pop_front();
        cs = seen_q.pop_front();
        `CHK(cn, ce, cs)
    end

    // Cycle ceiling cuts a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task note(input string nm, input logic [23:0] e, input logic [23:0] s);
        name_q.push_back(nm);
        exp_q.push_back(e);
        seen_q.push_back(s);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        tick(1);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = v;
        tick(1);
        cfg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        cfg_rd = 1'b1;
        cfg_addr = a;
        tick(1);
        cfg_rd = 1'b0;
        tick(1);
        note("register read", {16'h0, e}, {16'h0, cfg_rdata});
    endtask
    task pulse(input int n);
        tick(1);
        pl[n] = 1'b1;
        tick(1);
        pl[n] = 1'b0;
    endtask
    task wait_frame();
        n0 = frames;
        for (i = 0; i < 3000 && frames == n0; i++) @(posedge clock);
        tick(3);
    endtask
    task restart();
        pulse(4);
        tick(40);
        wait_frame();
    endtask
    task tally_and_finish();
        tick(2);
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        d = $urandom(72842);
        tick(2);
        sys_rst = 1'b0;
        for (k = 0; k < 3; k++) rd(`MTS_ADDR_DIR_ERR + k[7:0], `MTS_RST_REG);
        for (k = 0; k < 2; k++) begin
            r = $urandom;
            wr(`MTS_ADDR_DIR_ERR + k[7:0], r);
            rd(`MTS_ADDR_DIR_ERR + k[7:0], r);
        end
        wr(8'h11, 8'h5A);
        rd(8'h11, 8'h00);
        wr(`MTS_ADDR_MODE_SYNC, 8'h30);
        rd(`MTS_ADDR_MODE_SYNC, 8'h30);
        $display("test registers done");
        pulse(1);
        note("wrap down", 24'hFFFFFF, turn_count);
        pulse(0);
        pulse(0);
        note("count up", 24'h000001, turn_count);
        $display("test internal counter done");
        d = $urandom & 24'hFF;
        m_word = {22'h0, d[7:0], 2'b00};
        wr(`MTS_ADDR_OFFSET, 8'h00);
        wr(`MTS_ADDR_DIR_ERR, 8'h40);
        wr(`MTS_ADDR_MODE_SYNC, 8'h0C);
        restart();
        note("frame periods", 24'd11, {18'h0, m_last});
        note("startup held", 24'h0, {23'h0, startup_done});
        note("error bit", 24'h1, {23'h0, err_flag});
        m_word = {22'h0, d[7:0], 2'b01};
        wait_frame();
        note("startup done", 24'h1, {23'h0, startup_done});
        note("loaded count", d, turn_count);
        repeat (3) pulse(0);
        note("counted turns", d + 24'h3, turn_count);
        pulse(2);
        wait_frame();
        note("mismatch set", 24'h1, {23'h0, turn_mismatch_flag});
        pulse(3);
        note("mismatch cleared", 24'h0, {23'h0, turn_mismatch_flag});
        $display("test startup and verify done");
        wr(`MTS_ADDR_DIR_ERR, 8'hE0);
        m_word = {22'h0, d[7:0], 2'b00};
        restart();
        note("inverted turns", {16'h0, ~d[7:0]}, {16'h0, turn_count[7:0]});
        wr(`MTS_ADDR_DIR_ERR, 8'h00);
        d = $urandom & 24'hFF;
        m_len = 5'd9;
        m_word = {23'h0, d[7:0], 1'b0};
        restart();
        note("frame periods", 24'd10, {18'h0, m_last});
        note("loaded count", d, turn_count);
        pulse(0);
        wr(`MTS_ADDR_MODE_SYNC, 8'h4C);
        for (i = 0; i < 2000 && turn_mismatch_flag !== 1'b1; i++) tick(1);
        note("periodic mismatch", 24'h1, {23'h0, turn_mismatch_flag});
        $display("test direction and periodic check done");
        wr(`MTS_ADDR_MODE_SYNC, 8'h80);
        for (k = 0; k < 16; k++) begin
            port_a_mode_pending = k[2:0];
            access_level_pending = $urandom;
            serial_host_data_in = $urandom;
            ssi_option_bit = 1'b0;
            pulse(4);
            note("port mode", {21'h0, k[2:0]}, {21'h0, port_a_mode});
            note("access level", {22'h0, access_level_pending}, {22'h0, access_level});
            ssi_option_bit = k[3];
            ok = (k[2:0] == 3'h2) || (k[2:0] >= 3'h5 && k[3]);
            tick(1);
            note("chain active", {23'h0, ok}, {23'h0, chain_active});
            if (ok) repeat (4) begin
                #400 host_clock_in = ~host_clock_in;
                #10 note("turn clock", {23'h0, host_clock_in}, {23'h0, turn_clock_out});
                note("data select", {23'h0, turn_data_in}, {23'h0, host_data_sel});
            end
        end
        $display("test daisy chain done");
        tally_and_finish();
    end
endmodule
